// ### pfsac_ctrl.sv
// Behaviour
// - flash self readable and writable, no mode
// - data pair holds one 14-bit word
// - address pair holds 15-bit word address
// - internal timer times each write or erase
// - code protect refuses external read and write
// - code protect never blocks self write
// - only external bulk erase clears code protect
// - write protect field blocks self write, erase
// - write protect never restricts external programmer
// - read bit starts read, write bit starts write
// - start bits only settable; zero writes ignored
// - hardware clears start bits at completion
// - write proceeds only with write enable set
// - write enable cleared at power-up
// - reset during write sets error flag, kept
// - unlock key register write-only, reads zero
// - writes refused without the key pattern
// - key 55h, AAh, then write bit, uninterrupted
// - two forced nops, then stall until done
// - fetch on second cycle, data next cycle
//
// Chosen here: the register offsets and strobed register access.
`default_nettype none
module pfsac_ctrl
  import pfsac_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              por_i,
  input  wire logic [REG_AW-1:0] reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic              code_protect_bit_n_i,
  input  wire logic [1:0]        write_protect_field_i,
  input  wire pfsac_ext_req_t    ext_req_i,
  output logic                   ext_rd_grant_o,
  output logic                   ext_wr_grant_o,
  output pfsac_fl_req_t          fl_req_o,
  input  wire logic [FL_DW-1:0]  fl_rdata_i,
  output logic                   cpu_nop_o,
  output logic                   cpu_ignore_o,
  output logic                   cpu_stall_o
);

  logic [7:0]           addr_low_q;
  logic [ADDR_HI_W-1:0] addr_high_q;
  logic [7:0]           data_low_q;
  logic [DATA_HI_W-1:0] data_high_q;
  logic                 rd_q;
  logic                 wr_q;
  logic                 write_enable_bit_q;
  logic                 write_error_flag_q;
  logic                 free_q;
  logic                 lwlo_q;
  logic                 cp_prot_q;
  pfsac_state_t         state_q;
  pfsac_state_t         state_d;
  pfsac_key_t           key_q;
  logic [CNT_W-1:0]     cnt_q;
  logic [FL_AW-1:0]     fl_addr;
  logic                 ctl_we;
  logic                 start_wr;
  logic                 start_rd;
  logic                 wp_hit;

  assign fl_addr = {addr_high_q, addr_low_q};
  assign ctl_we  = reg_we_i && (reg_addr_i == REG_CONTROL);
  // latch loads are not flash writes, so protection skips them
  assign wp_hit = pfsac_wp_blocks(write_protect_field_i, fl_addr) && !reg_wdata_i[CTL_LWLO];

  // code protection plays no part in self access
  assign start_wr = ctl_we && reg_wdata_i[CTL_WR] && reg_wdata_i[CTL_WRITE_ENABLE_BIT]
                    && (key_q == KEY_ARMED) && !wp_hit
                    && (state_q == ST_IDLE);
  assign start_rd = ctl_we && reg_wdata_i[CTL_RD] && !start_wr && (state_q == ST_IDLE);

  // unlock key tracking; any other access between steps breaks it
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || por_i)
      key_q <= KEY_IDLE;
    else if (reg_we_i && reg_addr_i == REG_UNLOCK && reg_wdata_i == KEY_FIRST)
      key_q <= KEY_GOT_FIRST;
    else if (reg_we_i && reg_addr_i == REG_UNLOCK && reg_wdata_i == KEY_SECOND
             && key_q == KEY_GOT_FIRST)
      key_q <= KEY_ARMED;
    else if (reg_we_i || reg_re_i)
      key_q <= KEY_IDLE;
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (start_wr)
          state_d = ST_WR_NOP1;
        else if (start_rd)
          state_d = ST_RD_WAIT;
      end
      ST_RD_WAIT:  state_d = ST_RD_FETCH;
      ST_RD_FETCH: state_d = ST_IDLE;
      ST_WR_NOP1:  state_d = ST_WR_NOP2;
      ST_WR_NOP2:  state_d = lwlo_q ? ST_IDLE : ST_WR_BUSY;
      ST_WR_BUSY:
      begin
        if (cnt_q == '0)
          state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || por_i)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // internal write timer, software gives no duration
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || por_i)
      cnt_q <= '0;
    else if (state_q == ST_WR_NOP2)
      cnt_q <= CNT_W'(WRITE_CYCLES - 1);
    else if (state_q == ST_WR_BUSY && cnt_q != '0)
      cnt_q <= cnt_q - CNT_W'(1);
  end

  // address pair
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || por_i)
    begin
      addr_low_q  <= '0;
      addr_high_q <= '0;
    end
    else if (reg_we_i && reg_addr_i == REG_ADDR_LOW)
      addr_low_q  <= reg_wdata_i;
    else if (reg_we_i && reg_addr_i == REG_ADDR_HIGH)
      addr_high_q <= reg_wdata_i[ADDR_HI_W-1:0];
  end

  // data pair: read result wins over a software write in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || por_i)
    begin
      data_low_q  <= '0;
      data_high_q <= '0;
    end
    else if (state_q == ST_RD_FETCH)
    begin
      data_low_q  <= fl_rdata_i[7:0];
      data_high_q <= fl_rdata_i[FL_DW-1:8];
    end
    else if (reg_we_i && reg_addr_i == REG_DATA_LOW)
      data_low_q  <= reg_wdata_i;
    else if (reg_we_i && reg_addr_i == REG_DATA_HIGH)
      data_high_q <= reg_wdata_i[DATA_HI_W-1:0];
  end

  // start bits: set only by software, cleared only at completion or by reset
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || por_i)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      if (start_rd)
        rd_q <= 1'b1;
      else if (state_q == ST_RD_FETCH)
        rd_q <= 1'b0;
      if (start_wr)
        wr_q <= 1'b1;
      else if (state_q != ST_IDLE && state_d == ST_IDLE)
        wr_q <= 1'b0;
    end
  end

  // mode bits are frozen while an operation runs
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || por_i)
    begin
      write_enable_bit_q <= 1'b0;
      free_q <= 1'b0;
      lwlo_q <= 1'b0;
    end
    else if (ctl_we && state_q == ST_IDLE)
    begin
      write_enable_bit_q <= reg_wdata_i[CTL_WRITE_ENABLE_BIT];
      free_q <= reg_wdata_i[CTL_FREE];
      lwlo_q <= reg_wdata_i[CTL_LWLO];
    end
  end

  // error flag survives the ordinary reset; power-up or a control write with the bit at 0 clears it
  always_ff @(posedge core_clk_i)
  begin
    if (por_i)
      write_error_flag_q <= 1'b0;
    else if (rst_i && wr_q)
      write_error_flag_q <= 1'b1;
    else if (ctl_we && !rst_i)
      write_error_flag_q <= reg_wdata_i[CTL_WRITE_ERROR_FLAG];
  end

  // protection state caught at power-up; only bulk erase lifts it
  always_ff @(posedge core_clk_i)
  begin
    if (por_i)
      cp_prot_q <= ~code_protect_bit_n_i;
    else if (ext_req_i.bulk)
      cp_prot_q <= 1'b0;
  end

  // external programmer grants; write protect has no say here
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || por_i)
    begin
      ext_rd_grant_o <= 1'b0;
      ext_wr_grant_o <= 1'b0;
    end
    else
    begin
      ext_rd_grant_o <= ext_req_i.rd && !cp_prot_q;
      ext_wr_grant_o <= ext_req_i.wr && !cp_prot_q;
    end
  end

  // flash array requests and processor handshakes
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || por_i)
    begin
      fl_req_o     <= '0;
      cpu_nop_o    <= 1'b0;
      cpu_ignore_o <= 1'b0;
      cpu_stall_o  <= 1'b0;
    end
    else
    begin
      fl_req_o.rd    <= (state_d == ST_RD_FETCH);
      fl_req_o.latch <= start_wr && reg_wdata_i[CTL_LWLO];
      fl_req_o.erase <= (state_d == ST_WR_BUSY) && free_q;
      fl_req_o.prog  <= (state_d == ST_WR_BUSY) && !free_q;
      fl_req_o.bulk  <= ext_req_i.bulk;
      fl_req_o.addr  <= fl_addr;
      fl_req_o.wdata <= {data_high_q, data_low_q};
      cpu_nop_o      <= (state_d == ST_WR_NOP1) || (state_d == ST_WR_NOP2);
      cpu_ignore_o   <= (state_d == ST_RD_FETCH);
      cpu_stall_o    <= (state_d == ST_WR_BUSY);
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || por_i)
      reg_rdata_o <= '0;
    else if (reg_re_i)
    begin
      unique case (reg_addr_i)
        REG_ADDR_LOW:  reg_rdata_o <= addr_low_q;
        REG_ADDR_HIGH: reg_rdata_o <= {1'b0, addr_high_q};
        REG_DATA_LOW:  reg_rdata_o <= data_low_q;
        REG_DATA_HIGH: reg_rdata_o <= {2'b00, data_high_q};
        REG_CONTROL:   reg_rdata_o <= {2'b00, lwlo_q, free_q, write_error_flag_q, write_enable_bit_q, wr_q, rd_q};
        REG_UNLOCK:    reg_rdata_o <= 8'h00;
        default:       reg_rdata_o <= 8'h00;
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end

  // checks
  sequence s_read_fetch;
    ##2 (fl_req_o.rd && cpu_ignore_o) ##1 (!rd_q && !fl_req_o.rd);
  endsequence

  sequence s_two_nops;
    ##1 cpu_nop_o [*2] ##1 !cpu_nop_o;
  endsequence

  chk_key_reads_zero: assert property (
    @(posedge core_clk_i) disable iff (rst_i || por_i)
    reg_re_i && reg_addr_i == REG_UNLOCK |=> reg_rdata_o == 8'h00)
    else $error("unlock key register read back nonzero");

  chk_read_fetch_seq: assert property (
    @(posedge core_clk_i) disable iff (rst_i || por_i)
    start_rd |-> s_read_fetch)
    else $error("read fetch timing wrong");

  chk_read_data_lands: assert property (
    @(posedge core_clk_i) disable iff (rst_i || por_i)
    state_q == ST_RD_FETCH |=> {data_high_q, data_low_q} == $past(fl_rdata_i))
    else $error("read data not captured");

  chk_write_two_nops: assert property (
    @(posedge core_clk_i) disable iff (rst_i || por_i)
    start_wr |-> s_two_nops)
    else $error("forced nop count wrong");

  chk_stall_follows: assert property (
    @(posedge core_clk_i) disable iff (rst_i || por_i)
    start_wr && !reg_wdata_i[CTL_LWLO] |-> ##3 (cpu_stall_o && wr_q))
    else $error("stall did not follow the nops");

  chk_timer_bound: assert property (
    @(posedge core_clk_i) disable iff (rst_i || por_i)
    state_q == ST_WR_BUSY && cnt_q == '0 |=> !wr_q ##1 !cpu_stall_o)
    else $error("write not finished when timer expired");

  chk_bad_key_no_wr: assert property (
    @(posedge core_clk_i) disable iff (rst_i || por_i)
    ctl_we && reg_wdata_i[CTL_WR] && key_q != KEY_ARMED && !wr_q |=> !wr_q)
    else $error("write bit set without key sequence");

  chk_wr_needs_write_enable_bit: assert property (
    @(posedge core_clk_i) disable iff (rst_i || por_i)
    $rose(wr_q) |-> write_enable_bit_q)
    else $error("write started without write enable");

  chk_wp_blocks: assert property (
    @(posedge core_clk_i) disable iff (rst_i || por_i)
    $rose(fl_req_o.erase || fl_req_o.prog)
      |-> !pfsac_wp_blocks(write_protect_field_i, $past(fl_addr)))
    else $error("protected region written");

  chk_wr_set_only: assert property (
    @(posedge core_clk_i) disable iff (rst_i || por_i)
    wr_q && state_d != ST_IDLE |=> wr_q)
    else $error("write bit cleared before completion");

  chk_ext_cp_gate: assert property (
    @(posedge core_clk_i) disable iff (rst_i || por_i)
    ext_rd_grant_o || ext_wr_grant_o |-> !$past(cp_prot_q))
    else $error("external access granted under code protect");

  chk_write_error_flag_on_rst: assert property (
    @(posedge core_clk_i) disable iff (por_i)
    rst_i && wr_q |=> write_error_flag_q)
    else $error("error flag missed interrupted write");

  chk_write_enable_bit_por: assert property (
    @(posedge core_clk_i)
    por_i |=> !write_enable_bit_q && !wr_q)
    else $error("write enable not cleared at power-up");

endmodule : pfsac_ctrl
`default_nettype wire

// ### pfsac_flash_model.sv
`default_nettype none
module pfsac_flash_model
  import pfsac_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire pfsac_fl_req_t    fl_req_i,
  output logic      [FL_DW-1:0] fl_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [FL_DW-1:0] mem_q [int];
  logic [FL_DW-1:0] latch_q [int];
  logic             erase_q = 1'b0;
  logic             prog_q  = 1'b0;
  logic             flip_q  = 1'b0;
  logic [FL_DW-1:0] word;
  logic [FL_DW-1:0] lat;

  always @*
  begin
    word = mem_q.exists(int'(fl_req_i.addr)) ? mem_q[int'(fl_req_i.addr)] : {FL_DW{1'b1}};
    lat = latch_q.exists(int'(fl_req_i.addr)) ? latch_q[int'(fl_req_i.addr)] : {FL_DW{1'b1}};
    // no keeper on the read bus: outside a fetch it toggles every cycle
    fl_rdata_o = fl_req_i.rd ? word : {FL_DW{flip_q}};
  end

  always @(posedge core_clk_i)
  begin
    flip_q <= ~flip_q;
    erase_q <= fl_req_i.erase;
    prog_q <= fl_req_i.prog;
    if (fl_req_i.latch)
      latch_q[int'(fl_req_i.addr)] = fl_req_i.wdata;
    // bulk erase leaves every word blank
    if (fl_req_i.bulk)
      mem_q.delete();
    if (fl_req_i.erase && !erase_q)
      mem_q[int'(fl_req_i.addr)] = {FL_DW{1'b1}};
    // programming only clears bits, so an unerased word keeps its 0 bits
    if (fl_req_i.prog && !prog_q)
      mem_q[int'(fl_req_i.addr)] = word & lat;
  end
endmodule : pfsac_flash_model
`default_nettype wire

// ### pfsac_pkg.sv
`default_nettype none
package pfsac_pkg;

  // register indices on the plain register port
  localparam int unsigned REG_AW = 3;
  localparam logic [REG_AW-1:0] REG_ADDR_LOW  = 3'h0;
  localparam logic [REG_AW-1:0] REG_ADDR_HIGH = 3'h1;
  localparam logic [REG_AW-1:0] REG_DATA_LOW  = 3'h2;
  localparam logic [REG_AW-1:0] REG_DATA_HIGH = 3'h3;
  localparam logic [REG_AW-1:0] REG_CONTROL   = 3'h4;
  localparam logic [REG_AW-1:0] REG_UNLOCK    = 3'h5;

  // widths of the word and address pairs
  localparam int unsigned FL_AW      = 15;
  localparam int unsigned FL_DW      = 14;
  localparam int unsigned ADDR_HI_W  = FL_AW - 8;
  localparam int unsigned DATA_HI_W  = FL_DW - 8;

  // flash_control_reg bit positions
  localparam int unsigned CTL_RD    = 0;
  localparam int unsigned CTL_WR    = 1;
  localparam int unsigned CTL_WRITE_ENABLE_BIT  = 2;
  localparam int unsigned CTL_WRITE_ERROR_FLAG = 3;
  localparam int unsigned CTL_FREE  = 4;
  localparam int unsigned CTL_LWLO  = 5;
  localparam logic [7:0]  CTL_RESET = 8'h00;

  // unlock key pattern
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // timing
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned WRITE_TIME_US    = 2000;
  localparam int unsigned WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 18;

  // write protect field encodings and region limits
  localparam logic [1:0]       WP_NONE  = 2'h3;
  localparam logic [1:0]       WP_LOW   = 2'h2;
  localparam logic [1:0]       WP_HALF  = 2'h1;
  localparam logic [FL_AW-1:0] WP_LOW_LIMIT  = 15'h0200;
  localparam logic [FL_AW-1:0] WP_HALF_LIMIT = 15'h1000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_WAIT, ST_RD_FETCH, ST_WR_NOP1, ST_WR_NOP2, ST_WR_BUSY
  } pfsac_state_t;

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} pfsac_key_t;

  typedef struct packed {
    logic             rd;
    logic             latch;
    logic             erase;
    logic             prog;
    logic             bulk;
    logic [FL_AW-1:0] addr;
    logic [FL_DW-1:0] wdata;
  } pfsac_fl_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic bulk;
  } pfsac_ext_req_t;

  function automatic logic pfsac_wp_blocks(input logic [1:0] wrt,
                                           input logic [FL_AW-1:0] addr);
    logic hit;
    hit = 1'b1;
    unique case (wrt)
      WP_NONE: hit = 1'b0;
      WP_LOW:  hit = (addr < WP_LOW_LIMIT);
      WP_HALF: hit = (addr < WP_HALF_LIMIT);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction : pfsac_wp_blocks

endpackage : pfsac_pkg
`default_nettype wire

// ### tb_top.sv
`default_nettype none
module tb_top
  import pfsac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned WR_CYC = 8;  // short write time keeps the run brief
  localparam int          LIMIT  = 3000;

  logic              core_clk_i  = 1'b0;
  logic              rst_i       = 1'b1;
  logic              por_i       = 1'b1;
  logic [REG_AW-1:0] reg_addr_i  = '0;
  logic [7:0]        reg_wdata_i = '0;
  logic              reg_we_i    = 1'b0;
  logic              reg_re_i    = 1'b0;
  logic [7:0]        reg_rdata_o;
  logic              cp_n        = 1'b0;
  logic [1:0]        wp          = WP_NONE;
  pfsac_ext_req_t    ext_req     = '0;
  logic              ext_rd_grant_o;
  logic              ext_wr_grant_o;
  pfsac_fl_req_t     fl_req_o;
  logic [FL_DW-1:0]  fl_rdata_i;
  logic              cpu_nop_o;
  logic              cpu_ignore_o;
  logic              cpu_stall_o;
  logic              re_q        = 1'b0;
  logic [7:0]        exp_q[$];
  int                error_cnt   = 0;
  int                comparisons = 0;
  int                cyc = 0, nops = 0, stalls = 0, igns = 0;
  int                seed        = 52;

  always #4 core_clk_i = ~core_clk_i;

  pfsac_ctrl #(.WRITE_CYCLES(WR_CYC)) u_dut (
    .core_clk_i           (core_clk_i),
    .rst_i                (rst_i),
    .por_i                (por_i),
    .reg_addr_i           (reg_addr_i),
    .reg_wdata_i          (reg_wdata_i),
    .reg_we_i             (reg_we_i),
    .reg_re_i             (reg_re_i),
    .reg_rdata_o          (reg_rdata_o),
    .code_protect_bit_n_i (cp_n),
    .write_protect_field_i(wp),
    .ext_req_i            (ext_req),
    .ext_rd_grant_o       (ext_rd_grant_o),
    .ext_wr_grant_o       (ext_wr_grant_o),
    .fl_req_o             (fl_req_o),
    .fl_rdata_i           (fl_rdata_i),
    .cpu_nop_o            (cpu_nop_o),
    .cpu_ignore_o         (cpu_ignore_o),
    .cpu_stall_o          (cpu_stall_o)
  );

  pfsac_flash_model u_flash (
    .core_clk_i(core_clk_i),
    .fl_req_i  (fl_req_o),
    .fl_rdata_o(fl_rdata_i)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic bus(input logic we, input logic re, input logic [REG_AW-1:0] a,
                     input logic [7:0] d);
    reg_we_i <= we;
    reg_re_i <= re;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
  endtask : bus

  task automatic wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [REG_AW-1:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, REG_CONTROL, 8'h00);
  endtask : idle

  task automatic unlock();
    wr(REG_UNLOCK, KEY_FIRST);
    wr(REG_UNLOCK, KEY_SECOND);
  endtask : unlock

  task automatic set_addr(input logic [FL_AW-1:0] a);
    wr(REG_ADDR_LOW, a[7:0]);
    wr(REG_ADDR_HIGH, {1'b0, a[14:8]});
  endtask : set_addr

  task automatic op(input logic [7:0] ctl);
    unlock();
    wr(REG_CONTROL, ctl);
    idle(14);
  endtask : op

  task automatic fetch(input logic [FL_DW-1:0] exp);
    wr(REG_CONTROL, 8'h01);
    idle(3);
    rd(REG_DATA_LOW, exp[7:0]);
    rd(REG_DATA_HIGH, {2'h0, exp[13:8]});
    rd(REG_CONTROL, 8'h00);
  endtask : fetch

  task automatic ext(input logic [2:0] req, input logic [1:0] exp);
    ext_req <= req;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    check({14'h0, ext_rd_grant_o, ext_wr_grant_o}, {14'h0, exp});
    check({15'h0, fl_req_o.bulk}, {15'h0, req[0]});
    @(posedge core_clk_i);
  endtask : ext

  always @(posedge core_clk_i)
  begin
    re_q <= reg_re_i;
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  // read data stands only in the cycle after the strobe
  always @(negedge core_clk_i)
  begin
    if (cpu_nop_o === 1'b1)
      nops++;
    if (cpu_stall_o === 1'b1)
      stalls++;
    if (cpu_ignore_o === 1'b1)
      igns++;
    if (re_q)
      check({8'h0, reg_rdata_o}, {8'h0, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX});
  end

  initial
  begin : main
    logic [FL_DW-1:0] d;
    logic [FL_AW-1:0] a;
    logic [1:0]       w;
    logic             blk;
    int               s_nop;
    int               s_stall;
    int               s_ign;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    rd(REG_CONTROL, CTL_RESET);
    wr(REG_UNLOCK, KEY_FIRST);
    rd(REG_UNLOCK, 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    for (int r = 0; r < 4; r++)
      wr(REG_AW'(r), 8'hFF);
    rd(REG_ADDR_LOW, 8'hFF);
    rd(REG_ADDR_HIGH, 8'h7F);
    rd(REG_DATA_HIGH, 8'h3F);
    $display("test registers done");
    wr(REG_CONTROL, 8'h06);
    idle(1);
    rd(REG_CONTROL, 8'h04);
    wr(REG_UNLOCK, KEY_SECOND);
    wr(REG_UNLOCK, KEY_FIRST);
    wr(REG_CONTROL, 8'h06);
    idle(1);
    rd(REG_CONTROL, 8'h04);
    wr(REG_UNLOCK, KEY_FIRST);
    rd(REG_DATA_LOW, 8'hFF);
    wr(REG_UNLOCK, KEY_SECOND);
    wr(REG_CONTROL, 8'h06);
    idle(1);
    rd(REG_CONTROL, 8'h04);
    unlock();
    wr(REG_CONTROL, 8'h02);
    idle(1);
    rd(REG_CONTROL, 8'h00);
    $display("test unlock done");
    s_nop = nops;
    s_stall = stalls;
    s_ign = igns;
    d = 14'($random(seed));
    set_addr(15'h1234);
    unlock();
    wr(REG_CONTROL, 8'h16);
    wr(REG_CONTROL, 8'h00);
    rd(REG_CONTROL, 8'h16);
    idle(14);
    rd(REG_CONTROL, 8'h14);
    fetch(14'h3FFF);
    wr(REG_DATA_LOW, d[7:0]);
    wr(REG_DATA_HIGH, {2'h0, d[13:8]});
    op(8'h26);
    rd(REG_CONTROL, 8'h24);
    op(8'h06);
    rd(REG_CONTROL, 8'h04);
    fetch(d);
    idle(2);
    check(16'(stalls - s_stall), 16'(2 * WR_CYC));
    check(16'(nops - s_nop), 16'h0006);
    check(16'(igns - s_ign), 16'h0002);
    $display("test erase program read done");
    for (int i = 0; i < 8; i++)
    begin
      w = 2'(i);
      a = (i < 4) ? 15'h0100 : 15'h1100;
      blk = (w == WP_NONE) ? 1'b0 : (w == WP_LOW) ? (a < WP_LOW_LIMIT) :
            (w == WP_HALF) ? (a < WP_HALF_LIMIT) : 1'b1;
      wp <= w;
      set_addr(a);
      unlock();
      wr(REG_CONTROL, 8'h06);
      idle(1);
      rd(REG_CONTROL, blk ? 8'h04 : 8'h06);
      idle(14);
    end
    $display("test write protect done");
    wp <= 2'h0;
    ext(3'b100, 2'b00);
    ext(3'b010, 2'b00);
    ext(3'b001, 2'b00);
    ext(3'b100, 2'b10);
    ext(3'b010, 2'b01);
    ext(3'b000, 2'b00);
    $display("test external access done");
    wp <= WP_NONE;
    unlock();
    wr(REG_CONTROL, 8'h06);
    idle(5);
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    rd(REG_CONTROL, 8'h08);
    idle(1);
    por_i <= 1'b1;
    idle(2);
    por_i <= 1'b0;
    rd(REG_CONTROL, CTL_RESET);
    ext(3'b100, 2'b00);
    idle(2);
    $display("test reset done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
